/* inc/stage_pkg.sv */
// constants, register map and carrier types of the residual overvoltage
// stages; assumes a 250 MHz system clock and a 5 ms processing tick
package stage_pkg;
	localparam int CLK_PERIOD_NS    = 4;
	localparam int PROC_TICK_MS     = 5;
	localparam int PROC_TICK_CYCLES = PROC_TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BLOCK_LEAD_MS    = 5;
	localparam int TICKS_PER_S      = 1000 / PROC_TICK_MS;
	localparam int STAGES           = 4;
	localparam int RATIO_SCALE      = 100;
	localparam int PICK_RESET_PCT   = 97;

	localparam logic [5:0] REG_CTRL   = 6'h00;
	localparam logic [5:0] REG_PICKUP = 6'h04;
	localparam logic [5:0] REG_DEFDLY = 6'h08;
	localparam logic [5:0] REG_DIAL   = 6'h0C;
	localparam logic [5:0] REG_EXPO   = 6'h10;
	localparam logic [5:0] REG_RELDLY = 6'h14;
	localparam logic [5:0] REG_STATUS = 6'h18;
	localparam logic [5:0] REG_RATIO  = 6'h1C;
	localparam logic [5:0] REG_EXPECT = 6'h20;
	localparam logic [5:0] REG_REMAIN = 6'h24;

	localparam int CTRL_INVERSE_TIME_MODE    = 0;
	localparam int CTRL_DLY_REL = 1;
	localparam int CTRL_RST_AFT = 2;
	localparam int CTRL_CONT    = 3;
	localparam int CTRL_SRC     = 4;

	localparam logic [16:0] RATIO_MAX = 17'h1E848;
	localparam logic [18:0] TIME_MAX  = 19'h57E40;
	localparam logic [31:0] ACC_MAX   = 32'h7FFFFFFF;

	typedef struct packed {
		logic        inverse_time_mode;
		logic        dly_rel;
		logic        rst_aft;
		logic        cont;
		logic [1:0]  src;
		logic [15:0] thr;
		logic [18:0] defdly;
		logic [12:0] dial;
		logic [11:0] expo;
		logic [14:0] reldly;
	} cfg_type;

	localparam cfg_type CFG_RST = '{inverse_time_mode: 1'b0, dly_rel: 1'b1,
		rst_aft: 1'b1, cont: 1'b0, src: 2'h0, thr: 16'h07D0,
		defdly: 19'h00008, dial: 13'h0005, expo: 12'h064,
		reldly: 15'h000C};

	typedef struct packed {
		logic        pu;
		logic        start;
		logic        trip;
		logic        blocked;
		logic        rel_act;
		logic [18:0] cnt;
		logic [14:0] rel_cnt;
		logic [16:0] ratio;
		logic [18:0] target;
	} stage_type;

	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} phasor_type;

	typedef struct packed {
		phasor_type [2:0] ln;
		logic [15:0]      u3;
		logic [15:0]      u4;
		logic             ln_present;
		logic             u3_is_u0;
		logic             u4_is_u0;
	} meas_type;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} av_req_type;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} av_rsp_type;

	typedef enum logic [2:0] {
		ENG_IDLE  = 3'b000,
		ENG_RATIO = 3'b001,
		ENG_POW   = 3'b010,
		ENG_FRAC  = 3'b011,
		ENG_TIME  = 3'b100
	} eng_type;
endpackage : stage_pkg

/* hw/residual_overvoltage_stage.sv */
// four residual overvoltage stages with pick-up, blocking, timing modes,
// release handling, readback; assumes synchronous inputs, Avalon master
`timescale 1ns/1ps
module residual_overvoltage_stage #(
	parameter int unsigned TICK_CYCLES = stage_pkg::PROC_TICK_CYCLES
) (
	input  logic                 sys_clk,
	input  logic                 rst_n,
	input  stage_pkg::av_req_type av_req,
	output stage_pkg::av_rsp_type av_rsp,
	input  stage_pkg::meas_type  meas,
	input  logic [3:0]           residual_overvoltage_block,
	output logic [3:0]           start,
	output logic [3:0]           trip,
	output logic [3:0]           blocked
);
	import stage_pkg::*;

	typedef struct packed {
		logic [31:0]      tick_cnt;
		eng_type          eng;
		logic [1:0]       idx;
		logic [4:0]       n_left;
		logic [31:0]      acc;
		logic             ack;
		logic [31:0]      rdata;
		cfg_type [3:0]    cfg;
		stage_type [3:0]  stg;
	} state_type;

	state_type          st;
	state_type          next_st;
	logic               tick;
	logic [3:0]         pu_now;
	logic [3:0]         pu_eff;
	logic [18:0]        src_w [4];
	logic signed [17:0] sum_re;
	logic signed [17:0] sum_im;
	logic [17:0]        abs_re;
	logic [17:0]        abs_im;
	logic [15:0]        mx;
	logic [15:0]        mn;
	logic [16:0]        mag_raw;
	logic [15:0]        calc_mag;

	// computed residual: third of phasor sum, magnitude approximated
	assign sum_re = 18'(meas.ln[0].re) + 18'(meas.ln[1].re)
		+ 18'(meas.ln[2].re);
	assign sum_im = 18'(meas.ln[0].im) + 18'(meas.ln[1].im)
		+ 18'(meas.ln[2].im);
	assign abs_re = sum_re[17] ? 18'(-sum_re) : 18'(sum_re);
	assign abs_im = sum_im[17] ? 18'(-sum_im) : 18'(sum_im);
	assign mx = (abs_re > abs_im) ? 16'(abs_re / 3) : 16'(abs_im / 3);
	assign mn = (abs_re > abs_im) ? 16'(abs_im / 3) : 16'(abs_re / 3);
	assign mag_raw = 17'(mx) + 17'(mn >> 2) + 17'(mn >> 3);
	assign calc_mag = mag_raw[16] ? 16'hFFFF : mag_raw[15:0];

	// source select: {none, measuring now, magnitude}
	function automatic logic [18:0] pick_src(input logic [1:0] sel,
		input meas_type m, input logic [15:0] c);
		logic [18:0] r;
		r = {1'b1, 2'h0, 16'h0000};
		unique case (sel)
			2'h0, 2'h1: if (m.ln_present) r = {1'b0, 2'h1, c};
			2'h2: if (m.u3_is_u0) r = {1'b0, 2'h2, m.u3};
			2'h3: if (m.u4_is_u0) r = {1'b0, 2'h3, m.u4};
		endcase
		return r;
	endfunction : pick_src

	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : g_stage
			logic [15:0] um;
			logic [15:0] thr;
			assign src_w[g] = pick_src(st.cfg[g].src, meas, calc_mag);
			assign um = src_w[g][15:0];
			assign thr = st.cfg[g].thr;
			// hysteresis: rise above set value, fall below 97 %
			assign pu_now[g] = !src_w[g][18] && (st.stg[g].pu
				? (24'(um) * 24'(RATIO_SCALE) >=
					24'(thr) * 24'(PICK_RESET_PCT))
				: (um > thr));
			// blocking gates the pick-up after the comparator, ahead of the timing logic
			assign pu_eff[g] = pu_now[g]
				&& !residual_overvoltage_block[g];
			assign start[g] = st.stg[g].start;
			assign trip[g] = st.stg[g].trip;
			assign blocked[g] = st.stg[g].blocked;
		end
	endgenerate

	assign tick = st.tick_cnt == 32'(TICK_CYCLES - 1);
	assign av_rsp.waitrequest = (av_req.read || av_req.write) && !st.ack;
	assign av_rsp.readdata = st.rdata;

	always_comb begin
		logic [1:0]  s;
		logic [5:0]  off;
		logic [18:0] tgt;
		logic [18:0] cnt1;
		logic [15:0] rc1;
		logic        done;
		logic [63:0] p64;
		logic [16:0] r;
		logic [15:0] um;
		logic [19:0] remain;
		s = 2'h0;
		off = 6'h00;
		tgt = 19'h00000;
		cnt1 = 19'h00000;
		rc1 = 16'h0000;
		done = 1'b0;
		p64 = 64'h0;
		r = 17'h00000;
		um = 16'h0000;
		remain = 20'h00000;
		next_st = st;
		next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;

		// per-stage timing once per processing tick
		if (tick) begin
			for (int i = 0; i < STAGES; i++) begin
				tgt = st.cfg[i].inverse_time_mode ? st.stg[i].target
					: st.cfg[i].defdly;
				cnt1 = (st.stg[i].cnt == TIME_MAX) ? st.stg[i].cnt
					: st.stg[i].cnt + 19'h1;
				next_st.stg[i].pu = pu_now[i];
				next_st.stg[i].blocked = pu_now[i]
					&& residual_overvoltage_block[i];
				if (pu_eff[i]) begin
					next_st.stg[i].start = 1'b1;
					next_st.stg[i].rel_act = 1'b0;
					next_st.stg[i].rel_cnt = 15'h0000;
					next_st.stg[i].cnt = cnt1;
					// zero target trips with start
					next_st.stg[i].trip = cnt1 >= tgt;
				end else begin
					next_st.stg[i].trip = 1'b0;
					if (st.stg[i].start || st.stg[i].rel_act) begin
						rc1 = (st.stg[i].rel_act ? 16'(st.stg[i].rel_cnt)
							: 16'h0000) + 16'h1;
						done = rc1 >= 16'(st.cfg[i].reldly);
						if (done) begin
							next_st.stg[i].rel_act = 1'b0;
							next_st.stg[i].start = 1'b0;
							next_st.stg[i].rel_cnt = 15'h0000;
							if (st.cfg[i].rst_aft)
								next_st.stg[i].cnt = 19'h00000;
						end else begin
							next_st.stg[i].rel_act = 1'b1;
							next_st.stg[i].rel_cnt = rc1[14:0];
							// start held only for delayed release
							next_st.stg[i].start = st.cfg[i].dly_rel
								&& !residual_overvoltage_block[i];
						end
						if (!st.cfg[i].rst_aft)
							next_st.stg[i].cnt = 19'h00000;
						else if (st.cfg[i].cont && !done)
							next_st.stg[i].cnt = cnt1;
					end
				end
			end
		end

		// inverse-time engine, one step per cycle, all stages per tick
		s = st.idx;
		um = src_w[s][15:0];
		r = st.stg[s].ratio;
		unique case (st.eng)
			ENG_IDLE: ;
			ENG_RATIO: begin
				p64 = (st.cfg[s].thr == 16'h0000) ? 64'(RATIO_MAX)
					: 64'(um) * 64'(RATIO_SCALE) / 64'(st.cfg[s].thr);
				next_st.stg[s].ratio = (p64 > 64'(RATIO_MAX))
					? RATIO_MAX : p64[16:0];
				next_st.acc = 32'(RATIO_SCALE);
				next_st.n_left = 5'(st.cfg[s].expo / 12'(RATIO_SCALE));
				next_st.eng = ENG_POW;
			end
			ENG_POW: begin
				if (st.n_left == 5'h00) begin
					next_st.eng = ENG_FRAC;
				end else begin
					p64 = 64'(st.acc) * 64'(r) / 64'(RATIO_SCALE);
					next_st.acc = (p64 > 64'(ACC_MAX)) ? ACC_MAX : p64[31:0];
					next_st.n_left = st.n_left - 5'h01;
				end
			end
			ENG_FRAC: begin
				// fractional exponent by linear interpolation
				if (r > 17'(RATIO_SCALE)) begin
					p64 = 64'(st.acc) + 64'(st.acc) * 64'(r - 17'(RATIO_SCALE))
						* 64'(st.cfg[s].expo % 12'(RATIO_SCALE))
						/ 64'(RATIO_SCALE * RATIO_SCALE);
					next_st.acc = (p64 > 64'(ACC_MAX)) ? ACC_MAX : p64[31:0];
				end
				next_st.eng = ENG_TIME;
			end
			ENG_TIME: begin
				if (st.acc <= 32'(RATIO_SCALE)) begin
					next_st.stg[s].target = TIME_MAX;
				end else begin
					p64 = 64'(st.cfg[s].dial) * 64'(TICKS_PER_S)
						/ 64'(st.acc - 32'(RATIO_SCALE));
					next_st.stg[s].target = (p64 > 64'(TIME_MAX))
						? TIME_MAX : p64[18:0];
				end
				next_st.idx = s + 2'h1;
				next_st.eng = (s == 2'(STAGES - 1)) ? ENG_IDLE : ENG_RATIO;
			end
			default: next_st.eng = ENG_IDLE;
		endcase
		if (tick) begin
			next_st.eng = ENG_RATIO;
			next_st.idx = 2'h0;
		end

		// Avalon slave: one wait cycle, then answer
		s = av_req.address[7:6];
		off = av_req.address[5:0];
		next_st.ack = (av_req.read || av_req.write) && !st.ack;
		tgt = st.cfg[s].inverse_time_mode ? st.stg[s].target : st.cfg[s].defdly;
		remain = (st.stg[s].start && !st.stg[s].trip)
			? 20'(tgt) - 20'(st.stg[s].cnt) : 20'h00000;
		if (av_req.read && !st.ack) begin
			unique case (off)
				REG_CTRL: next_st.rdata = 32'({st.cfg[s].src,
					st.cfg[s].cont, st.cfg[s].rst_aft,
					st.cfg[s].dly_rel, st.cfg[s].inverse_time_mode});
				REG_PICKUP: next_st.rdata = 32'(st.cfg[s].thr);
				REG_DEFDLY: next_st.rdata = 32'(st.cfg[s].defdly);
				REG_DIAL:   next_st.rdata = 32'(st.cfg[s].dial);
				REG_EXPO:   next_st.rdata = 32'(st.cfg[s].expo);
				REG_RELDLY: next_st.rdata = 32'(st.cfg[s].reldly);
				REG_STATUS: next_st.rdata = 32'({src_w[s][17:16],
					src_w[s][18], st.stg[s].blocked, st.stg[s].trip,
					st.stg[s].start});
				REG_RATIO:  next_st.rdata = 32'(st.stg[s].ratio);
				REG_EXPECT: next_st.rdata = 32'(tgt);
				REG_REMAIN: next_st.rdata = {{12{remain[19]}}, remain};
				default:    next_st.rdata = 32'h00000000;
			endcase
		end
		if (av_req.write && st.ack) begin
			unique case (off)
				REG_CTRL: begin
					next_st.cfg[s].inverse_time_mode = av_req.writedata[CTRL_INVERSE_TIME_MODE];
					next_st.cfg[s].dly_rel = av_req.writedata[CTRL_DLY_REL];
					next_st.cfg[s].rst_aft = av_req.writedata[CTRL_RST_AFT];
					next_st.cfg[s].cont = av_req.writedata[CTRL_CONT];
					next_st.cfg[s].src =
						av_req.writedata[CTRL_SRC+1:CTRL_SRC];
				end
				REG_PICKUP: next_st.cfg[s].thr = av_req.writedata[15:0];
				REG_DEFDLY: next_st.cfg[s].defdly = av_req.writedata[18:0];
				REG_DIAL:   next_st.cfg[s].dial = av_req.writedata[12:0];
				REG_EXPO:   next_st.cfg[s].expo = av_req.writedata[11:0];
				REG_RELDLY: next_st.cfg[s].reldly = av_req.writedata[14:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.cfg <= {STAGES{CFG_RST}};
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	blk_first_a: assert property (tick && residual_overvoltage_block[0]
		&& pu_now[0] |=> st.stg[0].blocked)
		else $error("blocking not seen");
	blk_quiet_a: assert property (st.stg[0].blocked
		|-> !st.stg[0].start && !st.stg[0].trip)
		else $error("blocked stage active");
	trip_start_a: assert property (st.stg[0].trip |-> st.stg[0].start)
		else $error("trip without start");
	inst_trip_a: assert property ($rose(st.stg[0].start)
		&& !st.cfg[0].inverse_time_mode && st.cfg[0].defdly == 19'h0
		|-> st.stg[0].trip)
		else $error("instant trip late");
	dt_time_a: assert property ($rose(st.stg[0].trip) && !st.cfg[0].inverse_time_mode
		&& !st.cfg[0].cont && st.cfg[0].defdly != 19'h0
		|-> st.stg[0].cnt == st.cfg[0].defdly)
		else $error("definite delay wrong");
	imm_rel_a: assert property (tick && st.stg[0].start && !pu_eff[0]
		&& !st.cfg[0].dly_rel |=> !st.stg[0].start)
		else $error("start not dropped");
	cnt_clr_a: assert property (tick && st.stg[0].start && !pu_eff[0]
		&& !st.cfg[0].rst_aft |=> st.stg[0].cnt == 19'h0)
		else $error("counter not cleared");
	rel_notrip_a: assert property (st.stg[0].rel_act |-> !st.stg[0].trip)
		else $error("trip during release");
	cnt_hold_a: assert property (tick && st.stg[0].rel_act && !pu_eff[0]
		&& !st.cfg[0].cont && st.cfg[0].rst_aft
		&& 16'(st.stg[0].rel_cnt) + 16'h1 < 16'(st.cfg[0].reldly)
		|=> $stable(st.stg[0].cnt))
		else $error("counter moved in release");
	bus_ans_a: assert property (av_rsp.waitrequest |=> !av_rsp.waitrequest)
		else $error("bus answer late");

	no_src_pu_a: assert property (src_w[0][18]
		|-> !pu_now[0])
		else $error("pick-up without source");
	out_hold_a: assert property (!tick |=> $stable(st.stg[0].start)
		&& $stable(st.stg[0].trip)
		&& $stable(st.stg[0].blocked))
		else $error("outputs moved between ticks");
	pu_start_a: assert property (tick && pu_eff[0]
		|=> st.stg[0].start)
		else $error("start not raised");
	blk_drop_a: assert property (tick && residual_overvoltage_block[0]
		|=> !st.stg[0].start)
		else $error("start kept under blocking");
	idle_notrip_a: assert property (tick && !pu_eff[0]
		|=> !st.stg[0].trip)
		else $error("trip without pick-up");
	rel_end_a: assert property (tick && st.stg[0].rel_act && !pu_eff[0]
		&& 16'(st.stg[0].rel_cnt) + 16'h1
		>= 16'(st.cfg[0].reldly)
		|=> !st.stg[0].start && !st.stg[0].rel_act)
		else $error("release did not end");
	dly_hold_a: assert property (tick && st.stg[0].rel_act && !pu_eff[0]
		&& st.cfg[0].dly_rel && !residual_overvoltage_block[0]
		&& 16'(st.stg[0].rel_cnt) + 16'h1 < 16'(st.cfg[0].reldly)
		|=> st.stg[0].start)
		else $error("start not held in release");
	tick_wrap_a: assert property (tick |=> st.tick_cnt == 32'h0)
		else $error("tick counter not wrapped");
	ratio_sat_a: assert property (st.stg[0].ratio <= RATIO_MAX)
		else $error("ratio above ceiling");
	target_sat_a: assert property (st.stg[0].target <= TIME_MAX)
		else $error("target above ceiling");
	rd_load_a: assert property (av_req.read && av_rsp.waitrequest
		&& av_req.address == 8'h04
		|=> av_rsp.readdata == 32'($past(st.cfg[0].thr)))
		else $error("read data wrong");
	dt_early_a: assert property (tick && pu_eff[0] && !st.cfg[0].inverse_time_mode
		&& 20'(st.stg[0].cnt) + 20'h1 < 20'(st.cfg[0].defdly)
		|=> !st.stg[0].trip)
		else $error("definite trip early");
	dt_due_a: assert property (tick && pu_eff[0] && !st.cfg[0].inverse_time_mode
		&& 20'(st.stg[0].cnt) + 20'h1 >= 20'(st.cfg[0].defdly)
		|=> st.stg[0].trip)
		else $error("definite trip missing");
	inverse_time_mode_due_a: assert property (tick && pu_eff[0] && st.cfg[0].inverse_time_mode
		&& 20'(st.stg[0].cnt) + 20'h1 >= 20'(st.stg[0].target)
		|=> st.stg[0].trip)
		else $error("inverse trip missing");
	rst_clr_a: assert property (tick && st.stg[0].rel_act && !pu_eff[0]
		&& st.cfg[0].rst_aft && 16'(st.stg[0].rel_cnt) + 16'h1
		>= 16'(st.cfg[0].reldly)
		|=> st.stg[0].cnt == 19'h0)
		else $error("counter kept after release");
	cont_run_a: assert property (tick && st.stg[0].rel_act && !pu_eff[0]
		&& st.cfg[0].cont && st.cfg[0].rst_aft
		&& 16'(st.stg[0].rel_cnt) + 16'h1 < 16'(st.cfg[0].reldly)
		&& st.stg[0].cnt != TIME_MAX
		|=> st.stg[0].cnt == $past(st.stg[0].cnt) + 19'h1)
		else $error("counter stopped in release");

	dt_trip_c: cover property ($rose(st.stg[0].trip) && !st.cfg[0].inverse_time_mode);
	inverse_time_mode_trip_c: cover property ($rose(st.stg[0].trip) && st.cfg[0].inverse_time_mode);
	blocked_c: cover property ($rose(st.stg[0].blocked));
	rel_end_c: cover property ($fell(st.stg[0].rel_act)
		&& !st.stg[0].start);
endmodule : residual_overvoltage_stage

/* sim/residual_source_model.sv */
// model of the blocking matrix and the residual input channel
// assumes bench commands change right after a rising clock edge
`timescale 1ns/1ps
module residual_source_model (
	input  logic                sys_clk,
	input  logic [15:0]         u3_level,
	input  logic [3:0]          block_req,
	output stage_pkg::meas_type meas,
	output logic [3:0]          residual_overvoltage_block
);
	import stage_pkg::*;
	logic [15:0] u3_q;

	initial begin
		u3_q = 16'h0000;
		residual_overvoltage_block = 4'h0;
	end

	// channel and blocking follow the commands one cycle later
	always @(posedge sys_clk) begin
		u3_q <= u3_level;
		residual_overvoltage_block <= block_req;
	end

	// only the u3 channel is wired as residual input
	assign meas = '{ln: '0, u3: u3_q, u4: 16'h0000, ln_present: 1'b0,
		u3_is_u0: 1'b1, u4_is_u0: 1'b0};
endmodule : residual_source_model

/* sim/residual_overvoltage_stage_tb.sv */
// self-checking bench of stage 0 through register reads
// assumes stage_pkg and a short processing tick for simulation
`timescale 1ns/1ps
module residual_overvoltage_stage_tb;
	import stage_pkg::*;
	localparam int TC    = 20;
	localparam int LIMIT = 9000;
	logic        sys_clk;
	logic        rst_n;
	av_req_type  av_req;
	av_rsp_type  av_rsp;
	meas_type    meas;
	logic [3:0]  residual_overvoltage_block;
	logic [3:0]  start;
	logic [3:0]  trip;
	logic [3:0]  blocked;
	logic [15:0] u3_level;
	logic [3:0]  block_req;
	logic [31:0] exp_q[$];
	int          err_count;
	int          compares;
	int          cycles;
	int          phase;
	int          seed;
	logic [15:0] rnd;
	logic [5:0]  rv_a [6] = '{REG_CTRL, REG_PICKUP, REG_DEFDLY, REG_DIAL,
		REG_EXPO, REG_RELDLY};
	logic [31:0] rv_v [6] = '{32'h6, 32'h7D0, 32'h8, 32'h5, 32'h64, 32'hC};
	logic [31:0] hc_c [4] = '{32'h26, 32'h22, 32'h2E, 32'h24};
	logic [31:0] hc_s [4] = '{32'h21, 32'h21, 32'h21, 32'h20};
	logic [31:0] hc_r [4] = '{32'h4, 32'h7, 32'h2, 32'h4};

	residual_overvoltage_stage #(.TICK_CYCLES(TC)) residual_overvoltage_stage_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp),
		.meas(meas), .residual_overvoltage_block(residual_overvoltage_block),
		.start(start), .trip(trip), .blocked(blocked));

	residual_source_model residual_source_model_inst (
		.sys_clk(sys_clk), .u3_level(u3_level), .block_req(block_req),
		.meas(meas),
		.residual_overvoltage_block(residual_overvoltage_block));

	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;

	task automatic finish_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, want);
		end
	endtask : check

	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d, input logic [31:0] e);
		logic wait_seen;
		av_req <= '{read: !w, write: w, address: {2'b00, a}, writedata: d};
		if (!w) exp_q.push_back(e);
		do begin
			@(negedge sys_clk);
			wait_seen = av_rsp.waitrequest;
			@(posedge sys_clk);
		end while (wait_seen !== 1'b0);
		av_req <= '0;
		@(posedge sys_clk);
	endtask : bus

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, e);
	endtask : rd

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask : wr

	// wait for n tick periods, landing just after a tick
	task automatic mid(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			while (phase != 2) @(posedge sys_clk);
		end
	endtask : mid

	// result watcher: compares read data with the oldest note
	always @(negedge sys_clk) begin
		if (av_req.read === 1'b1 && av_rsp.waitrequest === 1'b0) begin
			check(av_rsp.readdata, exp_q.pop_front());
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 0;
		end else begin
			phase <= (phase == TC - 1) ? 0 : phase + 1;
		end
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			finish_test();
		end
	end

	initial begin
		rst_n = 1'b0;
		av_req = '0;
		u3_level = 16'h0000;
		block_req = 4'h0;
		seed = 62941;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++) rd(rv_a[i], rv_v[i]);
		rd(6'h3C, 32'h0);
		wr(REG_STATUS, 32'h7);
		rd(REG_STATUS, 32'h8);
		wr(REG_CTRL, 32'h26);
		// definite delay run with delayed release
		mid(1);
		u3_level <= 16'h09C4;
		mid(1);
		rd(REG_STATUS, 32'h21);
		rd(REG_REMAIN, 32'h7);
		rd(REG_EXPECT, 32'h8);
		rd(REG_RATIO, 32'h7D);
		mid(6);
		rd(REG_STATUS, 32'h21);
		mid(1);
		rd(REG_STATUS, 32'h23);
		u3_level <= 16'h0000;
		mid(1);
		rd(REG_STATUS, 32'h21);
		mid(10);
		rd(REG_STATUS, 32'h21);
		mid(1);
		rd(REG_STATUS, 32'h20);
		// release variants: hold, clear, continue, no delay
		for (int i = 0; i < 4; i++) begin
			wr(REG_CTRL, hc_c[i]);
			mid(1);
			u3_level <= 16'h09C4;
			mid(3);
			u3_level <= 16'h0000;
			mid(1);
			rd(REG_STATUS, hc_s[i]);
			mid(1);
			u3_level <= 16'h09C4;
			mid(1);
			rd(REG_REMAIN, hc_r[i]);
			u3_level <= 16'h0000;
			mid(3);
			rd(REG_STATUS, hc_s[i]);
			mid(12);
		end
		// pick-up under blocking
		wr(REG_CTRL, 32'h26);
		block_req <= 4'h1;
		mid(1);
		u3_level <= 16'h09C4;
		mid(1);
		rd(REG_STATUS, 32'h24);
		block_req <= 4'h0;
		u3_level <= 16'h0000;
		mid(14);
		// blocking after start
		u3_level <= 16'h09C4;
		mid(2);
		rd(REG_STATUS, 32'h21);
		block_req <= 4'h1;
		mid(1);
		rd(REG_STATUS, 32'h24);
		block_req <= 4'h0;
		u3_level <= 16'h0000;
		mid(14);
		// zero delay trips with start
		wr(REG_DEFDLY, 32'h0);
		u3_level <= 16'h09C4;
		mid(2);
		rd(REG_STATUS, 32'h23);
		u3_level <= 16'h0000;
		mid(14);
		wr(REG_DEFDLY, 32'h8);
		// reset ratio: 1941 holds, 1939 drops
		wr(REG_CTRL, 32'h24);
		u3_level <= 16'h09C4;
		mid(2);
		u3_level <= 16'h0795;
		mid(2);
		rd(REG_STATUS, 32'h21);
		u3_level <= 16'h0793;
		mid(1);
		rd(REG_STATUS, 32'h20);
		rd(REG_RATIO, 32'h60);
		mid(14);
		// random levels for the ratio readout
		for (int i = 0; i < 3; i++) begin
			rnd = 16'(2001 + ($unsigned($random(seed)) % 4000));
			u3_level <= rnd;
			mid(2);
			rd(REG_RATIO, 32'(int'(rnd) * 100 / 2000));
		end
		u3_level <= 16'h0000;
		mid(14);
		// inverse time at ratio 2: dial 0.05 s is ten ticks
		wr(REG_CTRL, 32'h27);
		u3_level <= 16'h0FA0;
		mid(3);
		rd(REG_EXPECT, 32'hA);
		u3_level <= 16'h0000;
		mid(14);
		finish_test();
	end
endmodule : residual_overvoltage_stage_tb
